// file: rtl/flash_mode_ctrl.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module flash_mode_ctrl
  import flash_mode_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_flash_protect_pin,
  input  wire logic        i_mode_select_zero_pin,
  input  wire logic        i_mode_select_one_pin,
  input  wire logic [7:2]  i_port8_in,
  output logic [7:2]       o_port8_out,
  output logic [7:2]       o_port8_oe,
  output logic [2:0]       o_mode,
  output logic             o_flash_ew_enable,
  output logic             o_flash_exec_block,
  output logic             o_flash_entry,
  output logic             o_serial1_boot_sync,
  output logic [31:0]      o_reset_vector,
  output logic [31:0]      o_ei_vector,
  input  wire logic [31:0] i_axi_awaddr,
  input  wire logic        i_axi_awvalid,
  output logic             o_axi_awready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0]  i_axi_wstrb,
  input  wire logic        i_axi_wvalid,
  output logic             o_axi_wready,
  output logic [1:0]       o_axi_bresp,
  output logic             o_axi_bvalid,
  input  wire logic        i_axi_bready,
  input  wire logic [31:0] i_axi_araddr,
  input  wire logic        i_axi_arvalid,
  output logic             o_axi_arready,
  output logic [31:0]      o_axi_rdata,
  output logic [1:0]       o_axi_rresp,
  output logic             o_axi_rvalid,
  input  wire logic        i_axi_rready
);

  logic        fp_prev_q;
  logic        entry_q;
  logic [7:2]  latch_q;
  logic [7:2]  dir_q;
  logic [7:0]  p8_rd;
  logic        aw_have_q;
  logic        w_have_q;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic        w_lane0_q;
  logic        wr_fire;
  logic        fp_fall;
  logic        wr_ctrl;
  logic        wr_p8;
  logic        wr_dir;

  mode_if mi ();

  assign mi.fp    = i_flash_protect_pin;
  assign mi.mode_select_zero_pin  = i_mode_select_zero_pin;
  assign mi.mode_select_one_pin  = i_mode_select_one_pin;
  assign mi.entry = entry_q;

  mode_decoder u_dec (
    .m (mi.dec)
  );

  // ----------------------------------------
  // flash entry bit
  // ----------------------------------------
  assign fp_fall = fp_prev_q && !i_flash_protect_pin;
  assign wr_fire = aw_have_q && w_have_q && !o_axi_bvalid;
  assign wr_ctrl = wr_fire && w_lane0_q && (aw_addr_q == ADDR_FLASH_CTRL);
  assign wr_p8   = wr_fire && w_lane0_q && (aw_addr_q == ADDR_PORT8_DATA);
  assign wr_dir  = wr_fire && w_lane0_q && (aw_addr_q == ADDR_PORT8_DIR);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fp_prev_q <= 1'b0;
    end else begin
      fp_prev_q <= i_flash_protect_pin;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      entry_q <= 1'b0;
    end else if (fp_fall || !i_flash_protect_pin) begin
      entry_q <= 1'b0;
    end else if (wr_ctrl) begin
      entry_q <= w_data_q[ENTRY_BIT];
    end
  end

  // ----------------------------------------
  // mode outputs
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mode              <= 3'h0;
      o_flash_ew_enable   <= 1'b0;
      o_flash_exec_block  <= 1'b0;
      o_flash_entry       <= 1'b0;
      o_serial1_boot_sync <= 1'b0;
      o_reset_vector      <= VEC_FLASH_RESET;
      o_ei_vector         <= VEC_EI_FLASH;
    end else begin
      o_mode              <= 3'(mi.mode);
      o_flash_ew_enable   <= mi.ew_enable;
      o_flash_exec_block  <= mi.ew_enable;
      o_flash_entry       <= entry_q;
      o_serial1_boot_sync <= (mi.mode == MODE_BOOT);
      o_reset_vector      <= mi.reset_vec;
      o_ei_vector         <= mi.ei_vec;
    end
  end

  // ----------------------------------------
  // port 8
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (wr_p8) begin
      latch_q <= w_data_q[7:2];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      dir_q <= PORT8_DIR_RST[7:2];
    end else if (wr_dir) begin
      dir_q <= w_data_q[7:2];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_port8_out <= 6'h00;
      o_port8_oe  <= 6'h00;
    end else begin
      o_port8_out <= dir_q & latch_q;
      o_port8_oe  <= dir_q;
    end
  end

  assign p8_rd[0] = i_mode_select_zero_pin;
  assign p8_rd[1] = i_mode_select_one_pin;

  for (genvar b = 2; b < 8; b++) begin : g_p8
    assign p8_rd[b] = dir_q[b] ? latch_q[b] : i_port8_in[b];
  end

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_axi_awready <= 1'b0;
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 32'h0000_0000;
    end else if (i_axi_awvalid && o_axi_awready) begin
      o_axi_awready <= 1'b0;
      aw_have_q     <= 1'b1;
      aw_addr_q     <= i_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q     <= 1'b0;
    end else if (!aw_have_q && !o_axi_bvalid) begin
      o_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_axi_wready <= 1'b0;
      w_have_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_lane0_q    <= 1'b0;
    end else if (i_axi_wvalid && o_axi_wready) begin
      o_axi_wready <= 1'b0;
      w_have_q     <= 1'b1;
      w_data_q     <= i_axi_wdata;
      w_lane0_q    <= i_axi_wstrb[0];
    end else if (wr_fire) begin
      w_have_q     <= 1'b0;
    end else if (!w_have_q && !o_axi_bvalid) begin
      o_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_axi_bvalid <= 1'b0;
      o_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      o_axi_bvalid <= 1'b1;
      if (aw_addr_q == ADDR_FLASH_CTRL || aw_addr_q == ADDR_MODE_STAT ||
          aw_addr_q == ADDR_PORT8_DATA || aw_addr_q == ADDR_PORT8_DIR) begin
        o_axi_bresp <= RESP_OKAY;
      end else begin
        o_axi_bresp <= RESP_SLVERR;
      end
    end else if (i_axi_bready) begin
      o_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid  <= 1'b0;
      o_axi_rdata   <= 32'h0000_0000;
      o_axi_rresp   <= RESP_OKAY;
    end else if (i_axi_arvalid && o_axi_arready) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid  <= 1'b1;
      o_axi_rresp   <= RESP_OKAY;
      o_axi_rdata   <= 32'h0000_0000;
      if (i_axi_araddr == ADDR_FLASH_CTRL) begin
        o_axi_rdata[ENTRY_BIT] <= entry_q;
      end else if (i_axi_araddr == ADDR_MODE_STAT) begin
        o_axi_rdata[2:0]           <= 3'(mi.mode);
        o_axi_rdata[STAT_EW_BIT]   <= mi.ew_enable;
        o_axi_rdata[STAT_BOOT_BIT] <= (mi.mode == MODE_BOOT);
      end else if (i_axi_araddr == ADDR_PORT8_DATA) begin
        o_axi_rdata[7:0] <= p8_rd;
      end else if (i_axi_araddr == ADDR_PORT8_DIR) begin
        o_axi_rdata[7:2] <= dir_q;
      end else begin
        o_axi_rresp <= RESP_SLVERR;
      end
    end else if (o_axi_rvalid) begin
      if (i_axi_rready) begin
        o_axi_rvalid <= 1'b0;
      end
    end else begin
      o_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_BOOT_VEC: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_flash_protect_pin && i_mode_select_zero_pin && !i_mode_select_one_pin)
    |=> (o_reset_vector == VEC_BOOT_RESET) && (o_mode == 3'(MODE_BOOT)))
    else $error("boot pins did not give boot reset vector");

  AST_FLASH_VEC: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_mode_select_zero_pin || !i_flash_protect_pin)
    |=> (o_reset_vector == VEC_FLASH_RESET))
    else $error("reset vector not at flash start");

  AST_SINGLE: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_mode_select_zero_pin && !i_mode_select_one_pin)
    |=> (o_mode == 3'(MODE_SINGLE)) && (o_flash_ew_enable == ($past(i_flash_protect_pin) &&
    $past(entry_q))))
    else $error("single-chip decode wrong");

  AST_EXTENSION: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_mode_select_zero_pin && i_mode_select_one_pin) |=> (o_mode == 3'(MODE_EXTENSION)))
    else $error("external extension decode wrong");

  AST_EI_VEC: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 o_ei_vector == (($past(i_flash_protect_pin) && $past(entry_q) &&
    !($past(i_mode_select_zero_pin) && $past(i_mode_select_one_pin))) ? VEC_EI_RAM : VEC_EI_FLASH))
    else $error("interrupt vector entry wrong");

  AST_EW_CAUSE: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(o_flash_ew_enable) |-> $past(i_flash_protect_pin) && $past(entry_q))
    else $error("program/erase entered without cause");

  AST_EW_REFUSE: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_flash_protect_pin ||
    (i_mode_select_zero_pin && !i_mode_select_one_pin && !i_flash_protect_pin))
    |=> !o_flash_ew_enable && !entry_q)
    else $error("program/erase not refused");

  AST_EXEC_BLOCK: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_flash_ew_enable |-> o_flash_exec_block && o_flash_entry)
    else $error("flash fetch not blocked");

  AST_P8_MODE: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_axi_arvalid && o_axi_arready && i_axi_araddr == ADDR_PORT8_DATA)
    |=> o_axi_rvalid && o_axi_rdata[1:0] == {$past(i_mode_select_one_pin),
    $past(i_mode_select_zero_pin)})
    else $error("port 8 mode bits wrong");

  AST_ENTRY_CLR: assert property (@(posedge i_mclk) disable iff (i_rst)
    fp_fall |=> !entry_q ##1 !o_flash_entry)
    else $error("entry bit not cleared on protect fall");

  AST_RESERVED: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_mode_select_zero_pin && i_mode_select_one_pin)
    |=> (o_mode == 3'(MODE_RESERVED)) && !o_flash_ew_enable)
    else $error("reserved pins entered a mode");

  AST_PROCESSOR: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_flash_protect_pin && i_mode_select_zero_pin && !i_mode_select_one_pin)
    |=> (o_mode == 3'(MODE_PROCESSOR)) && !o_flash_ew_enable)
    else $error("processor mode decode wrong");

  AST_BOOT_SERIAL: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_flash_protect_pin && i_mode_select_zero_pin && !i_mode_select_one_pin)
    |=> o_serial1_boot_sync)
    else $error("boot serial exchange not selected");

  AST_NO_SERIAL: assert property (@(posedge i_mclk) disable iff (i_rst)
    !(i_flash_protect_pin && i_mode_select_zero_pin && !i_mode_select_one_pin)
    |=> !o_serial1_boot_sync)
    else $error("boot serial exchange outside boot mode");

  AST_ENTRY_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wr_ctrl && w_data_q[ENTRY_BIT] && i_flash_protect_pin) |=> entry_q)
    else $error("entry bit write did not stick");

  AST_P8_PIN: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_axi_arvalid && o_axi_arready && i_axi_araddr == ADDR_PORT8_DATA)
    |=> ((o_axi_rdata[7:2] ^ $past(i_port8_in)) & ~$past(dir_q)) == 6'h00)
    else $error("port 8 input bits do not read the pins");

  AST_B_STANDS: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_axi_bvalid && !i_axi_bready) |=> o_axi_bvalid && $stable(o_axi_bresp))
    else $error("write response dropped before taken");

  AST_R_STANDS: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_axi_rvalid && !i_axi_rready)
    |=> o_axi_rvalid && $stable(o_axi_rdata) && $stable(o_axi_rresp))
    else $error("read data dropped before taken");

  AST_WR_REFUSE: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
    else $error("write accepted while response pending");

  AST_RD_REFUSE: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_axi_rvalid |-> !o_axi_arready)
    else $error("read accepted while data pending");

  COV_EW_SINGLE: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_flash_ew_enable && o_mode == 3'(MODE_SINGLE));
  COV_EW_BOOT: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_flash_ew_enable && o_mode == 3'(MODE_BOOT));
  COV_FP_DROP: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_flash_ew_enable ##1 fp_fall);
  COV_BAD_ADDR: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_axi_bvalid && o_axi_bresp == RESP_SLVERR);

endmodule : flash_mode_ctrl
`default_nettype wire

// file: rtl/flash_mode_pkg.sv
// Overview of operation
// - flash-protect high, mode0 high, mode1 low: boot mode, reset vector at boot area
// - outside boot mode the reset vector is the flash start address
// - both mode pins low: single-chip mode; program/erase only with flash-protect high
// - mode0 low, mode1 high: external extension; program/erase with flash-protect high
// - flash-protect high and entry bit set, mode pins not both high: interrupt entry in RAM, else flash
// - program/erase mode needs flash-protect high and software-set entry bit
// - program/erase refused in processor mode or with flash-protect low
// - during program/erase no instruction fetch from flash, only flash commands
// - boot mode exchanges programmer data over serial channel 1, clock-synchronous
// - port 8 bits 0 and 1 read mode pin levels; writes ignored
// - port 8 bits 2..7 read pin when direction 0, output latch when 1
// - port 8 data latch has no reset value
// - entry bit cleared on reset and on flash-protect falling edge
package flash_mode_pkg;

  typedef enum logic [2:0] {
    MODE_SINGLE,
    MODE_PROCESSOR,
    MODE_EXTENSION,
    MODE_BOOT,
    MODE_RESERVED
  } mode_e;

  localparam logic [31:0] ADDR_FLASH_CTRL = 32'h0080_0700;
  localparam logic [31:0] ADDR_MODE_STAT  = 32'h0080_0704;
  localparam logic [31:0] ADDR_PORT8_DATA = 32'h0080_0708;
  localparam logic [31:0] ADDR_PORT8_DIR  = 32'h0080_070c;

  localparam int          ENTRY_BIT       = 0;
  localparam int          STAT_EW_BIT     = 3;
  localparam int          STAT_BOOT_BIT   = 4;
  localparam logic [7:0]  PORT8_DIR_RST   = 8'h00;

  localparam logic [31:0] VEC_BOOT_RESET  = 32'h8000_0000;
  localparam logic [31:0] VEC_FLASH_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_EI_FLASH    = 32'h0000_0080;
  localparam logic [31:0] VEC_EI_RAM      = 32'h0080_4000;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : flash_mode_pkg

// file: rtl/mode_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module mode_decoder
  import flash_mode_pkg::*;
(
  mode_if.dec m
);

  // ----------------------------------------
  // operating mode
  // ----------------------------------------
  always_comb begin
    if (m.mode_select_zero_pin && m.mode_select_one_pin) begin
      m.mode = MODE_RESERVED;
    end else if (m.mode_select_zero_pin && m.fp) begin
      m.mode = MODE_BOOT;
    end else if (m.mode_select_zero_pin) begin
      m.mode = MODE_PROCESSOR;
    end else if (m.mode_select_one_pin) begin
      m.mode = MODE_EXTENSION;
    end else begin
      m.mode = MODE_SINGLE;
    end
  end

  // ----------------------------------------
  // program/erase enable and vectors
  // ----------------------------------------
  always_comb begin
    case (m.mode)
      MODE_SINGLE, MODE_EXTENSION, MODE_BOOT: m.ew_enable = m.fp && m.entry;
      default:                                m.ew_enable = 1'b0;
    endcase
  end

  always_comb begin
    if (m.mode == MODE_BOOT) begin
      m.reset_vec = VEC_BOOT_RESET;
    end else begin
      m.reset_vec = VEC_FLASH_RESET;
    end
  end

  always_comb begin
    if (m.ew_enable) begin
      m.ei_vec = VEC_EI_RAM;
    end else begin
      m.ei_vec = VEC_EI_FLASH;
    end
  end

endmodule : mode_decoder
`default_nettype wire

// file: rtl/mode_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mode_if;
  import flash_mode_pkg::*;
  logic        fp;
  logic        mode_select_zero_pin;
  logic        mode_select_one_pin;
  logic        entry;
  mode_e       mode;
  logic        ew_enable;
  logic [31:0] reset_vec;
  logic [31:0] ei_vec;
  modport dec (input fp, mode_select_zero_pin, mode_select_one_pin, entry, output mode, ew_enable, reset_vec, ei_vec);
  modport ctl (output fp, mode_select_zero_pin, mode_select_one_pin, entry, input mode, ew_enable, reset_vec, ei_vec);
endinterface : mode_if
`default_nettype wire

// file: tb/board_strap_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// board straps and port 8 pads
// ------------------------------------------
module board_strap_model (
  input  wire logic       i_mclk,
  input  wire logic [2:0] i_strap,
  input  wire logic [7:2] i_ext,
  input  wire logic [7:2] i_pad_out,
  input  wire logic [7:2] i_pad_oe,
  output logic            o_fp,
  output logic            o_mode_select_zero_pin,
  output logic            o_mode_select_one_pin,
  output logic [7:2]      o_pad
);
  // straps settle on a clock edge, as a synchronous level
  always_ff @(posedge i_mclk) begin
    o_fp   <= i_strap[2];
    o_mode_select_zero_pin <= i_strap[0];
    o_mode_select_one_pin <= i_strap[1];
  end
  // device drives where enabled, board elsewhere
  assign o_pad = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext);
endmodule : board_strap_model
`default_nettype wire

// file: tb/flash_mode_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_mode_ctrl_tb;
  import flash_mode_pkg::*;
  logic        clk, rst, fp, m0, m1, ew, xb, ent, boot;
  logic [2:0]  strap, mode;
  logic [7:2]  ext, pad, p8out, p8oe, dirv;
  logic [31:0] rv, ev, awaddr, wdata, araddr, rdata, d;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ewx;
  logic [1:0]  bresp, rresp, r;
  mode_e       em;
  int          err_total, cmp_count, i;

  flash_mode_ctrl dut_u (.i_mclk(clk), .i_rst(rst), .i_flash_protect_pin(fp),
    .i_mode_select_zero_pin(m0), .i_mode_select_one_pin(m1), .i_port8_in(pad),
    .o_port8_out(p8out), .o_port8_oe(p8oe), .o_mode(mode), .o_flash_ew_enable(ew),
    .o_flash_exec_block(xb), .o_flash_entry(ent), .o_serial1_boot_sync(boot),
    .o_reset_vector(rv), .o_ei_vector(ev), .i_axi_awaddr(awaddr),
    .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata),
    .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
    .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready));

  board_strap_model strap_u (.i_mclk(clk), .i_strap(strap), .i_ext(ext),
    .i_pad_out(p8out), .i_pad_oe(p8oe), .o_fp(fp), .o_mode_select_zero_pin(m0), .o_mode_select_one_pin(m1),
    .o_pad(pad));

  // ------------------------------------------
  // bus tasks and compare
  // ------------------------------------------
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    awaddr <= a; wdata <= v; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 100) err_total++;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 100) err_total++;
    @(posedge clk);
  endtask : axi_rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run

  // ------------------------------------------
  // clock, watchdog and tests
  // ------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial begin
    rst = 1'b1; strap = 3'b000; ext = 6'h15; err_total = 0; cmp_count = 0;
    awaddr = '0; wdata = '0; wstrb = '0; araddr = '0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    repeat (20) @(posedge clk);
    chk({29'h0, mode}, 32'(MODE_SINGLE));
    chk(ev, VEC_EI_FLASH);
    rst <= 1'b0;
    @(posedge clk);
    // every strap combination, entry bit requested in each
    for (i = 0; i < 8; i++) begin
      strap <= i[2:0];
      repeat (4) @(posedge clk);
      em = i[1] ? (i[0] ? MODE_RESERVED : MODE_EXTENSION)
                : (i[0] ? (i[2] ? MODE_BOOT : MODE_PROCESSOR) : MODE_SINGLE);
      ewx = i[2] && !(i[0] && i[1]);
      chk({29'h0, mode}, 32'(em));
      chk(rv, (em == MODE_BOOT) ? VEC_BOOT_RESET : VEC_FLASH_RESET);
      chk({31'h0, boot}, {31'h0, em == MODE_BOOT});
      axi_rd(ADDR_PORT8_DATA, d, r);
      chk({30'h0, d[1:0]}, {30'h0, i[1:0]});
      axi_wr(ADDR_FLASH_CTRL, 32'h1, r);
      repeat (4) @(posedge clk);
      chk({31'h0, ent}, {31'h0, i[2]});
      chk({31'h0, ew}, {31'h0, ewx});
      chk({31'h0, xb}, {31'h0, ewx});
      chk(ev, ewx ? VEC_EI_RAM : VEC_EI_FLASH);
      axi_rd(ADDR_MODE_STAT, d, r);
      chk(d, {27'h0, em == MODE_BOOT, ewx, 3'(em)});
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      axi_wr(ADDR_FLASH_CTRL, 32'h0, r);
    end
    // entry bit dropped by protect low and by reset
    strap <= 3'b100;
    repeat (4) @(posedge clk);
    axi_wr(ADDR_FLASH_CTRL, 32'h1, r);
    strap <= 3'b000;
    repeat (4) @(posedge clk);
    strap <= 3'b100;
    repeat (4) @(posedge clk);
    chk({31'h0, ent}, 32'h0);
    axi_wr(ADDR_FLASH_CTRL, 32'h1, r);
    repeat (3) @(posedge clk);
    chk({31'h0, ent}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, ent}, 32'h0);
    chk({31'h0, ew}, 32'h0);
    // port 8 pad read-back by direction
    strap <= 3'b101;
    axi_rd(ADDR_PORT8_DIR, d, r);
    chk(d, {24'h0, PORT8_DIR_RST});
    dirv = 6'b000011;
    axi_wr(ADDR_PORT8_DIR, {24'h0, dirv, 2'b00}, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    axi_wr(ADDR_PORT8_DATA, 32'hff, r);
    repeat (3) @(posedge clk);
    chk({26'h0, p8oe}, {26'h0, dirv});
    chk({26'h0, p8out}, {26'h0, dirv});
    axi_rd(ADDR_PORT8_DATA, d, r);
    chk(d, {24'h0, (ext & ~dirv) | dirv, 2'b01});
    // unmapped place
    axi_rd(32'h0080_0710, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    axi_wr(32'h0080_0710, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    complete_run();
  end
endmodule : flash_mode_ctrl_tb
`default_nettype wire
